/* src/osd_pkg.sv */
package osd_pkg;

	// ----------------------------------------
	// register map (apb byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
	localparam logic [11:0] CLK_DIV_ADDR  = 12'h004;

	// ----------------------------------------
	// oscillator_control fields
	// ----------------------------------------
	localparam int CUR_SRC_LSB = 12;
	localparam int NEW_SRC_LSB = 8;
	localparam int SEL_LOCK_BIT = 7;
	localparam int PLL_LOCK_BIT = 5;
	localparam int CLK_FAIL_BIT = 3;
	localparam int SEC_DRV_BIT  = 2;
	localparam int SEC_EN_BIT   = 1;
	localparam int SW_TRIG_BIT  = 0;

	// ----------------------------------------
	// clock_divider fields and reset values
	// ----------------------------------------
	localparam int ROI_BIT       = 15;
	localparam int DOZE_LSB      = 12;
	localparam int DOZE_EN_BIT   = 11;
	localparam int RCDIV_LSB     = 8;
	localparam logic [2:0] DOZE_RST  = 3'h3;
	localparam logic [2:0] RCDIV_RST = 3'h1;

	// ----------------------------------------
	// unlock keys and timing
	// ----------------------------------------
	localparam logic [7:0] HI_KEY1 = 8'h78;
	localparam logic [7:0] HI_KEY2 = 8'h9a;
	localparam logic [7:0] LO_KEY1 = 8'h46;
	localparam logic [7:0] LO_KEY2 = 8'h57;
	localparam logic [3:0] NEW_CLK_EDGES = 4'ha;
	localparam logic [1:0] CFG_SETTLE    = 2'h3;

	// ----------------------------------------
	// source codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRC_FRC         = 3'h0,
		SRC_FRC_PLL     = 3'h1,
		SRC_PRI         = 3'h2,
		SRC_PRI_PLL     = 3'h3,
		SRC_SEC         = 3'h4,
		SRC_LOW_POWER_RC_OSC        = 3'h5,
		SRC_SLOW_RC_DIV = 3'h6,
		SRC_FAST_RC_DIV = 3'h7
	} osd_src_t;

	typedef struct packed {
		logic [1:0] switch_monitor_cfg_field;
		logic [2:0] initial_source_cfg;
		logic [1:0] primary_mode_cfg;
		logic       secondary_input_type_cfg;
	} osd_cfg_t;

	typedef struct packed {
		logic [2:0] target_source;
		logic       target_request;
		logic       switch_enable;
		logic       fail_safe_enable;
	} osd_sel_t;

endpackage : osd_pkg

/* src/osd_top.sv */
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module osd_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire osd_pkg::osd_cfg_t cfg_in,
	input  wire logic        new_osc_clk,
	input  wire logic        new_osc_ready,
	input  wire logic        pll_locked,
	input  wire logic        clock_fail,
	input  wire logic        irq,
	output osd_pkg::osd_sel_t sel_out,
	output logic [2:0]       current_source,
	output logic             secondary_enable,
	output logic             secondary_high_power,
	output logic             periph_clk_en,
	output logic             cpu_clk_en
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic uses_pll(input logic [2:0] s);
		uses_pll = (s == osd_pkg::SRC_PRI_PLL) || (s == osd_pkg::SRC_FRC_PLL);
	endfunction : uses_pll

	function automatic logic [7:0] pow2_last(input logic [2:0] c);
		pow2_last = 8'((9'h001 << c) - 9'h001);
	endfunction : pow2_last

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// straps are static, so one sync chain per bit is enough
	osd_pkg::osd_cfg_t cfg_m_q, cfg_s_q;
	logic [3:0] pin_m_q, pin_s_q;
	logic       nclk_d1_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_m_q   <= '0;
			cfg_s_q   <= '0;
			pin_m_q   <= 4'h0;
			pin_s_q   <= 4'h0;
			nclk_d1_q <= 1'b0;
		end else begin
			cfg_m_q   <= cfg_in;
			cfg_s_q   <= cfg_m_q;
			pin_m_q   <= {new_osc_clk, new_osc_ready, pll_locked, clock_fail};
			pin_s_q   <= pin_m_q;
			nclk_d1_q <= pin_s_q[3];
		end
	end

	wire new_clk_rise = pin_s_q[3] & ~nclk_d1_q;
	wire ready_s      = pin_s_q[2];
	wire pll_s        = pin_s_q[1];
	wire fail_s       = pin_s_q[0];

	wire sw_en = ~cfg_s_q.switch_monitor_cfg_field[1];
	wire fs_en = (cfg_s_q.switch_monitor_cfg_field == 2'h0);

	// ----------------------------------------
	// power-on load of source from config
	// ----------------------------------------
	// sources read fast rc with postscaler until the straps are through the sync
	logic [1:0] settle_q;
	wire        cfg_load = (settle_q == osd_pkg::CFG_SETTLE - 2'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settle_q <= 2'h0;
		else if (settle_q != osd_pkg::CFG_SETTLE)
			settle_q <= settle_q + 2'h1;
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready;
	wire hit_osc  = (paddr == osd_pkg::OSC_CTRL_ADDR);
	wire hit_div  = (paddr == osd_pkg::CLK_DIV_ADDR);
	wire wr_osc   = access & pwrite & hit_osc;
	wire wr_div   = access & pwrite & hit_div;
	wire wr_hi    = wr_osc & pstrb[1];
	wire wr_lo    = wr_osc & pstrb[0];
	wire [7:0] hb = pwdata[15:8];
	wire [7:0] lb = pwdata[7:0];

	// ----------------------------------------
	// unlock sequences
	// ----------------------------------------
	// any other write between key and payload breaks the sequence
	logic [1:0] hi_key_q, lo_key_q;
	wire        any_wr   = access & pwrite;
	wire        hi_open  = (hi_key_q == 2'h2);
	wire        lo_open  = (lo_key_q == 2'h2);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_key_q <= 2'h0;
			lo_key_q <= 2'h0;
		end else if (any_wr) begin
			if (wr_hi && hb == osd_pkg::HI_KEY1)
				hi_key_q <= 2'h1;
			else if (wr_hi && hb == osd_pkg::HI_KEY2 && hi_key_q == 2'h1)
				hi_key_q <= 2'h2;
			else
				hi_key_q <= 2'h0;
			if (wr_lo && lb == osd_pkg::LO_KEY1)
				lo_key_q <= 2'h1;
			else if (wr_lo && lb == osd_pkg::LO_KEY2 && lo_key_q == 2'h1)
				lo_key_q <= 2'h2;
			else
				lo_key_q <= 2'h0;
		end
	end

	// ----------------------------------------
	// oscillator_control state
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_RDY, ST_COUNT} osd_sw_t;
	osd_sw_t    sw_q;
	logic [2:0] cur_q, new_q;
	logic       sel_lock_q, pll_lock_q, fail_q, drv_q, sec_en_q, trig_q;
	logic [3:0] edge_cnt_q;

	wire locked    = fs_en & sel_lock_q;
	wire can_sel   = sw_en & ~locked;
	wire new_wr    = wr_hi & hi_open & can_sel & (sw_q == ST_IDLE);
	wire trig_wr   = wr_lo & lo_open & can_sel & lb[osd_pkg::SW_TRIG_BIT]
	                 & (sw_q == ST_IDLE);
	wire [2:0] new_next = new_wr ? hb[2:0] : new_q;
	wire redundant = trig_wr & (new_next == cur_q);
	wire sw_start  = trig_wr & ~redundant;
	wire rdy_ok    = ready_s & (~uses_pll(new_q) | pll_s);
	wire sw_done   = (sw_q == ST_COUNT) & new_clk_rise
	                 & (edge_cnt_q == osd_pkg::NEW_CLK_EDGES - 4'h1);
	wire [2:0] pll_src = (sw_q == ST_IDLE) ? cur_q : new_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_q       <= ST_IDLE;
			edge_cnt_q <= 4'h0;
		end else begin
			case (sw_q)
				ST_IDLE: begin
					edge_cnt_q <= 4'h0;
					if (sw_start)
						sw_q <= ST_WAIT_RDY;
				end
				ST_WAIT_RDY: begin
					if (rdy_ok)
						sw_q <= ST_COUNT;
				end
				ST_COUNT: begin
					if (sw_done)
						sw_q <= ST_IDLE;
					else if (new_clk_rise)
						edge_cnt_q <= edge_cnt_q + 4'h1;
				end
				default: sw_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_q <= osd_pkg::SRC_FAST_RC_DIV;
			new_q <= osd_pkg::SRC_FAST_RC_DIV;
		end else if (cfg_load) begin
			cur_q <= cfg_s_q.initial_source_cfg;
			new_q <= cfg_s_q.initial_source_cfg;
		end else begin
			if (sw_done)
				cur_q <= new_q;
			if (new_wr)
				new_q <= hb[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_lock_q <= 1'b0;
			pll_lock_q <= 1'b0;
			fail_q     <= 1'b0;
			drv_q      <= 1'b0;
			sec_en_q   <= 1'b0;
			trig_q     <= 1'b0;
		end else begin
			if (wr_lo && lb[osd_pkg::SEL_LOCK_BIT])
				sel_lock_q <= 1'b1;
			if (sw_start || !uses_pll(pll_src))
				pll_lock_q <= 1'b0;
			else
				pll_lock_q <= pll_s;
			// a failure in the clearing cycle still wins
			if (fs_en && fail_s)
				fail_q <= 1'b1;
			else if (sw_start || (wr_lo && !lb[osd_pkg::CLK_FAIL_BIT]))
				fail_q <= 1'b0;
			if (wr_lo) begin
				drv_q    <= lb[osd_pkg::SEC_DRV_BIT];
				sec_en_q <= lb[osd_pkg::SEC_EN_BIT];
			end
			if (!sw_en || redundant || sw_done)
				trig_q <= 1'b0;
			else if (sw_start)
				trig_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// clock_divider
	// ----------------------------------------
	logic       roi_q, cpu_slowdown_enable_q;
	logic [2:0] doze_q, rcdiv_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			roi_q   <= 1'b0;
			cpu_slowdown_enable_q <= 1'b0;
			doze_q  <= osd_pkg::DOZE_RST;
			rcdiv_q <= osd_pkg::RCDIV_RST;
		end else begin
			if (wr_div && pstrb[1]) begin
				roi_q   <= pwdata[osd_pkg::ROI_BIT];
				doze_q  <= pwdata[osd_pkg::DOZE_LSB +: 3];
				rcdiv_q <= pwdata[osd_pkg::RCDIV_LSB +: 3];
			end
			// hardware clear beats a same-cycle software set
			if (irq && roi_q)
				cpu_slowdown_enable_q <= 1'b0;
			else if (wr_div && pstrb[1])
				cpu_slowdown_enable_q <= pwdata[osd_pkg::DOZE_EN_BIT];
		end
	end

	// ----------------------------------------
	// clock enables
	// ----------------------------------------
	wire rc_div_src = (cur_q == osd_pkg::SRC_FAST_RC_DIV) || (cur_q == osd_pkg::SRC_FRC_PLL)
	                  || (cur_q == osd_pkg::SRC_SLOW_RC_DIV);
	wire [7:0] ps_last = !rc_div_src ? 8'h00 :
	                     (rcdiv_q == 3'h7) ? 8'hff : pow2_last(rcdiv_q);
	wire [7:0] dz_last = cpu_slowdown_enable_q ? pow2_last(doze_q) : 8'h00;
	logic [7:0] ps_cnt_q, dz_cnt_q;
	wire        ps_tick = (ps_cnt_q >= ps_last);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_cnt_q      <= 8'h00;
			dz_cnt_q      <= 8'h00;
			periph_clk_en <= 1'b0;
			cpu_clk_en    <= 1'b0;
		end else begin
			ps_cnt_q      <= ps_tick ? 8'h00 : ps_cnt_q + 8'h01;
			periph_clk_en <= ps_tick;
			cpu_clk_en    <= 1'b0;
			if (ps_tick) begin
				dz_cnt_q   <= (dz_cnt_q >= dz_last) ? 8'h00 : dz_cnt_q + 8'h01;
				cpu_clk_en <= (dz_cnt_q >= dz_last);
			end
		end
	end

	// ----------------------------------------
	// read mux and registered outputs
	// ----------------------------------------
	wire [15:0] osc_rd = {1'b0, cur_q, 1'b0, new_q, sel_lock_q, 1'b0, pll_lock_q, 1'b0,
	                      fail_q, drv_q, sec_en_q, trig_q};
	wire [15:0] div_rd = {roi_q, doze_q, cpu_slowdown_enable_q, rcdiv_q, 8'h00};
	wire [31:0] rd_mux = hit_osc ? {16'h0000, osc_rd} :
	                     hit_div ? {16'h0000, div_rd} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready               <= 1'b0;
			prdata               <= 32'h00000000;
			pslverr              <= 1'b0;
			sel_out              <= '0;
			current_source       <= osd_pkg::SRC_FAST_RC_DIV;
			secondary_enable     <= 1'b0;
			secondary_high_power <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~(hit_osc | hit_div);
			prdata  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
			sel_out.target_source    <= new_q;
			sel_out.target_request   <= (sw_q != ST_IDLE);
			sel_out.switch_enable    <= sw_en;
			sel_out.fail_safe_enable <= fs_en;
			current_source           <= cur_q;
			secondary_enable         <= sec_en_q;
			secondary_high_power     <= cfg_s_q.secondary_input_type_cfg
			                            & (drv_q | cfg_s_q.primary_mode_cfg[0]);
		end
	end

endmodule : osd_top

/* tb/osd_monitor.sv */
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module osd_monitor (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic              pready,
	input wire logic [31:0]       prdata,
	input wire osd_pkg::osd_cfg_t cfg_in,
	input wire osd_pkg::osd_sel_t sel_out,
	input wire logic [2:0]        current_source,
	input wire logic              secondary_high_power,
	input wire logic              periph_clk_en,
	input wire logic              cpu_clk_en
);
	logic rd_osc;
	logic rd_div;
	assign rd_osc = pready && !pwrite && paddr == osd_pkg::OSC_CTRL_ADDR;
	assign rd_div = pready && !pwrite && paddr == osd_pkg::CLK_DIV_ADDR;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_HI_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	AST_OSC_GAPS: assert property (rd_osc |-> {prdata[15], prdata[11], prdata[6], prdata[4]} == 4'h0)
		else $error("osc ctrl gap bit set");
	AST_DIV_GAPS: assert property (rd_div |-> prdata[7:0] == 8'h00)
		else $error("divider low byte not zero");
	AST_CUR_SHOWN: assert property (rd_osc |-> prdata[14:12] == current_source)
		else $error("current source field differs from port");
	AST_SW_CFG: assert property ($stable(cfg_in) [*6] |->
		sel_out.switch_enable == !cfg_in.switch_monitor_cfg_field[1])
		else $error("switch enable does not follow strap");
	AST_FSM_CFG: assert property ($stable(cfg_in) [*6] |->
		sel_out.fail_safe_enable == (cfg_in.switch_monitor_cfg_field == 2'h0))
		else $error("monitor enable does not follow strap");
	AST_NO_REQ: assert property (!sel_out.switch_enable |-> !sel_out.target_request)
		else $error("switch running while disabled");
	AST_REDUNDANT: assert property ($rose(sel_out.target_request) |->
		sel_out.target_source != current_source)
		else $error("redundant switch started");
	AST_CHANGEOVER: assert property (sel_out.target_request ##1 !sel_out.target_request |->
		current_source == $past(sel_out.target_source))
		else $error("switch ended without change over");
	AST_CPU_IN_PERIPH: assert property (cpu_clk_en |-> periph_clk_en)
		else $error("cpu pulse without peripheral pulse");
	AST_NO_POST: assert property ((!(current_source inside {3'h7, 3'h1, 3'h6})) [*3]
		|-> periph_clk_en)
		else $error("peripheral divided without postscaled source");
	AST_DIGITAL_SEC: assert property ((!cfg_in.secondary_input_type_cfg) [*4]
		|-> !secondary_high_power)
		else $error("high power with digital secondary input");
endmodule : osd_monitor

bind osd_top osd_monitor i_osd_monitor (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .prdata(prdata), .cfg_in(cfg_in), .sel_out(sel_out),
	.current_source(current_source), .secondary_high_power(secondary_high_power),
	.periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en));

/* tb/osd_top_tb.sv */
`timescale 1ns/1ps
module osd_top_tb;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic              new_osc_clk, new_osc_ready, pll_locked, clock_fail, irq;
	logic              secondary_enable, secondary_high_power, periph_clk_en, cpu_clk_en;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [3:0]        pstrb;
	logic [2:0]        current_source;
	logic              err;
	osd_pkg::osd_cfg_t cfg_in;
	osd_pkg::osd_sel_t sel_out;
	int                mismatches, n_compared, p, c;

	osd_top i_osd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .cfg_in(cfg_in), .new_osc_clk(new_osc_clk),
		.new_osc_ready(new_osc_ready), .pll_locked(pll_locked), .clock_fail(clock_fail),
		.irq(irq), .sel_out(sel_out), .current_source(current_source),
		.secondary_enable(secondary_enable), .secondary_high_power(secondary_high_power),
		.periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en));

	// ------------------------------
	// bus and check tasks
	// ------------------------------
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	// outputs are read right after the edge, i.e. the values sampled there
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		xfer(1'b1, a, d, s);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 4'h0);
		chk(rd, exp);
	endtask : rdc

	task automatic keys(input logic hi);
		if (hi) begin
			wr(12'h000, 32'h7800, 4'h2);
			wr(12'h000, 32'h9a00, 4'h2);
		end else begin
			wr(12'h000, 32'h0046, 4'h1);
			wr(12'h000, 32'h0057, 4'h1);
		end
	endtask : keys

	// polls the trigger bit until the switch is over; a hang counts as a mismatch
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			xfer(1'b0, 12'h000, 32'h0, 4'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 60);
		if (rd[0] !== 1'b0) mismatches++;
	endtask : wait_done

	task automatic pulse_irq();
		@(posedge pclk);
		irq <= 1'b1;
		@(posedge pclk);
		irq <= 1'b0;
	endtask : pulse_irq

	// counts pulses after a settling span, so divider phase does not matter
	task automatic cnt(input int w, input int m);
		repeat (w) @(posedge pclk);
		p = 0;
		c = 0;
		repeat (m) begin
			@(posedge pclk);
			p += int'(periph_clk_en);
			c += int'(cpu_clk_en);
		end
	endtask : cnt

	task automatic do_reset(input logic [1:0] mon, input logic [2:0] src, input logic [1:0] pm);
		presetn <= 1'b0;
		cfg_in <= {mon, src, pm, 1'b1};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask : do_reset

	// ------------------------------
	// clocks and watchdog
	// ------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		new_osc_clk = 1'b0;
		forever #170 new_osc_clk = ~new_osc_clk;
	end
	initial begin
		#3000000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{new_osc_ready, pll_locked, clock_fail, irq} = '0;
		presetn = 1'b0;
		cfg_in = {2'h0, 3'h7, 2'h3, 1'b1};
		mismatches = 0;
		n_compared = 0;
		do_reset(2'h0, 3'h7, 2'h2);
		rdc(12'h000, 32'h7700);
		chk(secondary_high_power, 1'b0);
		rdc(12'h004, 32'h3100);
		rdc(12'h008, 32'h0);
		chk(err, 1'b1);
		wr(12'h004, 32'h9a00, 4'h3);
		rdc(12'h004, 32'h9a00);
		cnt(8, 64);
		chk(p, 16);
		chk(c, 8);
		pulse_irq();
		rdc(12'h004, 32'h9200);
		cnt(8, 64);
		chk(c, 16);
		wr(12'h004, 32'h1a00, 4'h3);
		pulse_irq();
		rdc(12'h004, 32'h1a00);
		wr(12'h004, 32'h0700, 4'h3);
		cnt(300, 512);
		chk(p, 2);
		chk(c, 2);
		// ------------------------------
		// source switch
		// ------------------------------
		keys(1'b1);
		wr(12'h000, 32'h0000, 4'h2);
		rdc(12'h000, 32'h7000);
		keys(1'b0);
		wr(12'h000, 32'h0007, 4'h1);
		rdc(12'h000, 32'h7007);
		chk(secondary_enable, 1'b1);
		chk(secondary_high_power, 1'b1);
		chk(sel_out.target_request, 1'b1);
		@(posedge pclk);
		new_osc_ready <= 1'b1;
		wait_done();
		chk(current_source, 3'h0);
		rdc(12'h000, 32'h0006);
		keys(1'b0);
		wr(12'h000, 32'h0007, 4'h1);
		rdc(12'h000, 32'h0006);
		keys(1'b1);
		wr(12'h000, 32'h0700, 4'h2);
		keys(1'b0);
		wr(12'h000, 32'h0086, 4'h1);
		keys(1'b0);
		wr(12'h000, 32'h0087, 4'h1);
		rdc(12'h000, 32'h0786);
		@(posedge pclk);
		clock_fail <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc(12'h000, 32'h078e);
		wr(12'h000, 32'h0086, 4'h1);
		rdc(12'h000, 32'h078e);
		clock_fail <= 1'b0;
		repeat (4) @(posedge pclk);
		wr(12'h000, 32'h0086, 4'h1);
		rdc(12'h000, 32'h0786);
		wr(12'h000, 32'h008e, 4'h1);
		rdc(12'h000, 32'h0786);
		cfg_in.secondary_input_type_cfg <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(secondary_high_power, 1'b0);
		// switching disabled by strap: new source and trigger ignored
		do_reset(2'h2, 3'h5, 2'h3);
		rdc(12'h000, 32'h5500);
		chk(sel_out.switch_enable, 1'b0);
		keys(1'b1);
		wr(12'h000, 32'h0000, 4'h2);
		keys(1'b0);
		wr(12'h000, 32'h0001, 4'h1);
		rdc(12'h000, 32'h5500);
		chk(sel_out.target_request, 1'b0);
		chk(secondary_enable, 1'b0);
		chk(secondary_high_power, 1'b1);
		// monitor off: lock bit must not block a switch
		do_reset(2'h1, 3'h6, 2'h3);
		rdc(12'h000, 32'h6600);
		cnt(8, 64);
		chk(p, 32);
		pll_locked <= 1'b1;
		keys(1'b1);
		wr(12'h000, 32'h0100, 4'h2);
		keys(1'b0);
		wr(12'h000, 32'h0080, 4'h1);
		keys(1'b0);
		wr(12'h000, 32'h0081, 4'h1);
		rdc(12'h000, 32'h61a1);
		wait_done();
		chk(current_source, 3'h1);
		rdc(12'h000, 32'h11a0);
		keys(1'b1);
		wr(12'h000, 32'h0000, 4'h2);
		keys(1'b0);
		wr(12'h000, 32'h0081, 4'h1);
		rdc(12'h000, 32'h1081);
		report_and_stop();
	end
endmodule : osd_top_tb
